// ==== verilog/status_led_pattern_driver.sv ====
// front panel status bar and channel indicator driver
// Summary of operation
// RULE1: after power-on, yellow blinks at 1 Hz for the initial state.
// RULE2: start-up blinks green at 2 Hz for at least three seconds.
// RULE3: stopped state holds yellow steadily lit.
// RULE4: error state holds red steadily lit.
// RULE5: running without error: green steady, red dark.
// RULE6: running with error or warning: green steady, red blinks 1 Hz.
// RULE7: holding point reached: red steady, green blinks 1 Hz.
// RULE8: start-up diagnostics: red blinks 1 Hz, green blinks 2 Hz.
// RULE9: card write on system error: red and yellow steady meanwhile; the code does not show it in the latched end state.
// RULE10: hardware configuration load blinks yellow at 2 Hz.
// RULE11: blink test blinks green at 1 Hz.
// RULE12: card access flickers green when running, yellow when stopped.
// RULE13: memory reset: 1 Hz requested, 2 Hz executing, steady done.
// RULE14: factory reset: yellow 2 Hz, then red and yellow 1 Hz.
// RULE15: new firmware present: red and yellow alternate at 1 Hz.
// RULE16: firmware update: yellow 2 Hz, flicker on access, then both 1 Hz.
// RULE17: failed firmware update blinks only red at 1 Hz.
// RULE18: sixteen input indicators follow the input levels.
// RULE19: twelve output indicators follow the output levels.
// RULE20: three supply indicators lit while each supply is present.
// RULE21: output fault indicator lit while an output fault exists.
// RULE22: one shared 50 percent divider makes 1 Hz, 2 Hz and flicker.
`default_nettype none
module status_led_pattern_driver
    import led_pkg::*;
#(
    parameter int unsigned QUARTER_LEN = QUARTER_CYCLES,
    parameter int unsigned STARTUP_QUARTERS = STARTUP_MIN_QUARTERS
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // cpu operating state, same clock domain
    input wire logic cpu_startup,
    input wire logic cpu_run,
    input wire logic cpu_stop,
    input wire logic cpu_error,
    input wire logic cpu_warning,
    input wire logic hold_point,
    input wire logic startup_diag,
    input wire logic sys_error_card_write,
    input wire logic hw_config_load,
    input wire logic blink_test,
    input wire logic card_access,
    // overall memory reset
    input wire logic mem_reset_request,
    input wire logic mem_reset_exec,
    input wire logic mem_reset_done,
    // factory reset
    input wire logic factory_reset_exec,
    input wire logic factory_reset_done,
    // firmware update
    input wire logic fw_available,
    input wire logic fw_update_exec,
    input wire logic fw_update_done,
    input wire logic fw_update_fail,
    // field levels, asynchronous to clk
    input wire logic [NUM_DI-1:0] di_level,
    input wire logic [NUM_DO-1:0] do_level,
    input wire logic input_supply_good,
    input wire logic output_supply_good,
    input wire logic electronics_supply_good,
    input wire logic output_fault,
    // status bar
    output logic led_green,
    output logic led_yellow,
    output logic led_red,
    // channel indicators
    output logic [NUM_DI-1:0] led_di,
    output logic [NUM_DO-1:0] led_do,
    output logic [NUM_SUPPLY-1:0] led_supply,
    output logic output_fault_indicator,
    // status
    output logic startup_hold_active
);
    // ************************************************************
    // pattern selection
    // ************************************************************
    typedef enum logic [6:0] {
        ST_POWERON = 7'b000_0001,
        ST_STARTUP = 7'b000_0010,
        ST_OPER = 7'b000_0100,
        ST_MRESET = 7'b000_1000,
        ST_FACTORY = 7'b001_0000,
        ST_FWUPD = 7'b010_0000,
        ST_LATCHED = 7'b100_0000
    } mode_t;

    mode_t mode_reg;
    logic quarter_tick;
    logic p2;
    logic p1;
    logic pf;
    logic [7:0] startup_cnt_reg;
    logic startup_min_met;
    logic latch_fail_reg;
    logic g_next;
    logic y_next;
    logic r_next;

    blink_timebase #(
        .QUARTER_LEN(QUARTER_LEN)
    ) u_timebase (
        .clk(clk),
        .nrst(nrst),
        .quarter_tick(quarter_tick),
        .phase_2hz(p2),
        .phase_1hz(p1),
        .phase_flicker(pf)
    );

    // ************************************************************
    // field input synchronisers
    // ************************************************************
    localparam int unsigned FIELD_W = NUM_DI + NUM_DO + NUM_SUPPLY + 1;
    logic [FIELD_W-1:0] field_meta_reg;
    logic [FIELD_W-1:0] field_sync_reg;

    // two flops, field pins are not on clk
    always_ff @(posedge clk) begin
        if (!nrst) begin
            field_meta_reg <= '0;
            field_sync_reg <= '0;
        end else begin
            field_meta_reg <= {output_fault, electronics_supply_good, output_supply_good,
                               input_supply_good, do_level, di_level};
            field_sync_reg <= field_meta_reg;
        end
    end

    // indicators follow synced levels directly
    always_ff @(posedge clk) begin
        if (!nrst) begin
            led_di <= '0;
            led_do <= '0;
            led_supply <= '0;
            output_fault_indicator <= 1'b0;
        end else begin
            led_di <= field_sync_reg[NUM_DI-1:0]; // see RULE18
            led_do <= field_sync_reg[NUM_DI +: NUM_DO]; // see RULE19
            led_supply[SUPPLY_IN_BIT] <= field_sync_reg[NUM_DI+NUM_DO]; // see RULE20
            led_supply[SUPPLY_OUT_BIT] <= field_sync_reg[NUM_DI+NUM_DO+1]; // see RULE20
            led_supply[SUPPLY_EL_BIT] <= field_sync_reg[NUM_DI+NUM_DO+2]; // see RULE20
            output_fault_indicator <= field_sync_reg[FIELD_W-1]; // see RULE21
        end
    end

    // ************************************************************
    // start-up minimum hold
    // ************************************************************
    // counts quarters inside start-up; start-up pattern stays until met
    always_ff @(posedge clk) begin
        if (!nrst) begin
            startup_cnt_reg <= 8'h00;
        end else if (mode_reg != ST_STARTUP) begin
            startup_cnt_reg <= 8'h00;
        end else if (quarter_tick && !startup_min_met) begin
            startup_cnt_reg <= startup_cnt_reg + 8'h01; // see RULE2
        end
    end
    assign startup_min_met = (startup_cnt_reg >= 8'(STARTUP_QUARTERS));

    // ************************************************************
    // mode sequencer
    // ************************************************************
    // end states of factory and firmware reset wait for power cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_reg <= ST_POWERON;
            latch_fail_reg <= 1'b0;
        end else begin
            unique case (mode_reg)
                ST_POWERON: begin
                    if (cpu_startup) begin
                        mode_reg <= ST_STARTUP;
                    end else if (cpu_run || cpu_stop || cpu_error) begin
                        mode_reg <= ST_OPER;
                    end
                end
                ST_STARTUP: begin
                    // leaving early is refused until three seconds passed
                    if (!cpu_startup && startup_min_met) begin
                        mode_reg <= ST_OPER; // see RULE2
                    end
                end
                ST_OPER, ST_MRESET, ST_FACTORY, ST_FWUPD: begin
                    if (factory_reset_done || fw_update_done || fw_update_fail) begin
                        mode_reg <= ST_LATCHED;
                        latch_fail_reg <= fw_update_fail && !fw_update_done;
                    end else if (factory_reset_exec) begin
                        mode_reg <= ST_FACTORY;
                    end else if (fw_update_exec) begin
                        mode_reg <= ST_FWUPD;
                    end else if (mem_reset_request || mem_reset_exec || mem_reset_done) begin
                        mode_reg <= ST_MRESET;
                    end else if (cpu_startup) begin
                        mode_reg <= ST_STARTUP;
                    end else begin
                        mode_reg <= ST_OPER;
                    end
                end
                ST_LATCHED: begin
                    mode_reg <= ST_LATCHED;
                end
                default: begin
                    mode_reg <= ST_POWERON;
                end
            endcase
        end
    end

    // ************************************************************
    // status bar pattern
    // ************************************************************
    // priority: card write on error first except in the latched end state, then special modes, then state
    always_comb begin
        g_next = 1'b0;
        y_next = 1'b0;
        r_next = 1'b0;
        if (sys_error_card_write && mode_reg != ST_LATCHED) begin
            r_next = 1'b1; // see RULE9
            y_next = 1'b1; // see RULE9
        end else begin
            unique case (mode_reg)
                ST_POWERON: y_next = p1; // see RULE1
                ST_STARTUP: begin
                    g_next = p2; // see RULE2
                    if (startup_diag) begin
                        r_next = p1; // see RULE8
                    end
                end
                ST_MRESET: begin
                    if (mem_reset_exec) begin
                        y_next = p2; // see RULE13
                    end else if (mem_reset_request) begin
                        y_next = p1; // see RULE13
                    end else begin
                        y_next = 1'b1; // see RULE13
                    end
                end
                ST_FACTORY: y_next = p2; // see RULE14
                ST_FWUPD: y_next = card_access ? pf : p2; // see RULE16
                ST_LATCHED: begin
                    // fail: red only; success of either reset: both together
                    r_next = p1; // see RULE14 RULE16 RULE17
                    y_next = latch_fail_reg ? 1'b0 : p1; // see RULE17
                end
                ST_OPER: begin
                    if (fw_available) begin
                        r_next = p1; // see RULE15
                        y_next = !p1; // see RULE15
                    end else if (hw_config_load) begin
                        y_next = p2; // see RULE10
                    end else if (blink_test) begin
                        g_next = p1; // see RULE11
                    end else if (startup_diag) begin
                        r_next = p1; // see RULE8
                        g_next = p2; // see RULE8
                    end else if (cpu_run) begin
                        // flicker only interrupts the steady green
                        g_next = card_access ? pf : 1'b1; // see RULE5 RULE12
                        r_next = (cpu_error || cpu_warning) ? p1 : 1'b0; // see RULE6
                    end else if (cpu_stop && hold_point) begin
                        r_next = 1'b1; // see RULE7
                        g_next = p1; // see RULE7
                    end else if (cpu_error) begin
                        r_next = 1'b1; // see RULE4
                    end else if (cpu_stop) begin
                        y_next = card_access ? pf : 1'b1; // see RULE3 RULE12
                    end
                end
                default: begin
                    y_next = 1'b0;
                end
            endcase
        end
    end

    // registered so every lamp output comes straight from a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            led_green <= 1'b0;
            led_yellow <= 1'b0;
            led_red <= 1'b0;
            startup_hold_active <= 1'b0;
        end else begin
            led_green <= g_next;
            led_yellow <= y_next;
            led_red <= r_next;
            startup_hold_active <= (mode_reg == ST_STARTUP) && !startup_min_met;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_di_follow;
        @(posedge clk) disable iff (!nrst)
        $past(nrst, 3) |-> led_di == $past(di_level, 3);
    endproperty
    a_di_follow: assert property (p_di_follow) else $error("di lamp wrong"); // see RULE18

    property p_do_follow;
        @(posedge clk) disable iff (!nrst)
        $past(nrst, 3) |-> led_do == $past(do_level, 3);
    endproperty
    a_do_follow: assert property (p_do_follow) else $error("do lamp wrong"); // see RULE19

    property p_fault_follow;
        @(posedge clk) disable iff (!nrst)
        $past(nrst, 3) |-> output_fault_indicator == $past(output_fault, 3);
    endproperty
    a_fault_follow: assert property (p_fault_follow) else $error("fault lamp wrong"); // see RULE21

    property p_supply_follow;
        @(posedge clk) disable iff (!nrst)
        $past(nrst, 3) |-> led_supply[SUPPLY_EL_BIT] == $past(electronics_supply_good, 3);
    endproperty
    a_supply_follow: assert property (p_supply_follow) // see RULE20
        else $error("supply lamp wrong");

    sequence s_card_err;
        sys_error_card_write && mode_reg != ST_LATCHED;
    endsequence
    property p_card_write;
        @(posedge clk) disable iff (!nrst)
        s_card_err |=> led_red && led_yellow;
    endproperty
    a_card_write: assert property (p_card_write) // see RULE9
        else $error("card write lamps wrong");

    property p_startup_hold;
        @(posedge clk) disable iff (!nrst)
        (mode_reg == ST_STARTUP && !startup_min_met) |=> mode_reg == ST_STARTUP;
    endproperty
    a_startup_hold: assert property (p_startup_hold) // see RULE2
        else $error("start-up left early");

    property p_fw_alternate;
        @(posedge clk) disable iff (!nrst)
        (mode_reg == ST_OPER && fw_available && !sys_error_card_write) |=> led_red != led_yellow;
    endproperty
    a_fw_alternate: assert property (p_fw_alternate) // see RULE15
        else $error("fw lamps not alternate");

    property p_fail_red_only;
        @(posedge clk) disable iff (!nrst)
        (mode_reg == ST_LATCHED && latch_fail_reg) |=> !led_yellow && !led_green;
    endproperty
    a_fail_red_only: assert property (p_fail_red_only) // see RULE17
        else $error("fail shows other lamp");

    property p_run_green;
        @(posedge clk) disable iff (!nrst)
        (mode_reg == ST_OPER && cpu_run && !card_access && !fw_available && !hw_config_load
         && !blink_test && !startup_diag && !sys_error_card_write) |=> led_green;
    endproperty
    a_run_green: assert property (p_run_green) else $error("run green dark"); // see RULE5
endmodule // status_led_pattern_driver
`default_nettype wire

// ==== verilog/led_pkg.sv ====
// shared constants for the status led pattern driver
`default_nettype none
package led_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BLINK_HZ_SLOW = 1;
    localparam int unsigned QUARTER_PER_SEC = 4;
    // a quarter second tick drives both blink rates
    localparam int unsigned QUARTER_CYCLES = CLK_HZ / QUARTER_PER_SEC;
    localparam int unsigned STARTUP_MIN_S = 3;
    localparam int unsigned STARTUP_MIN_QUARTERS = STARTUP_MIN_S * QUARTER_PER_SEC;
    // flicker period is 2^FLICKER_SHIFT cycles, about 48 Hz at 50 MHz
    localparam int unsigned FLICKER_SHIFT = 20;
    // ************************************************************
    // channel counts
    // ************************************************************
    localparam int unsigned NUM_DI = 16;
    localparam int unsigned NUM_DO = 12;
    localparam int unsigned SUPPLY_IN_BIT = 0;
    localparam int unsigned SUPPLY_OUT_BIT = 1;
    localparam int unsigned SUPPLY_EL_BIT = 2;
    localparam int unsigned NUM_SUPPLY = 3;
endpackage
`default_nettype wire

// ==== verilog/blink_timebase.sv ====
// shared blink divider: quarter tick, 2 Hz, 1 Hz and flicker phases
`default_nettype none
module blink_timebase
    import led_pkg::*;
#(
    parameter int unsigned QUARTER_LEN = QUARTER_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // phases
    output logic quarter_tick,
    output logic phase_2hz,
    output logic phase_1hz,
    output logic phase_flicker
);
    // ************************************************************
    // divider
    // ************************************************************
    logic [31:0] div_reg;
    logic [1:0] quarter_reg;
    logic [FLICKER_SHIFT-1:0] flick_reg;

    // one counter so both rates stay locked in phase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_reg <= 32'h0000_0000;
            quarter_tick <= 1'b0;
        end else if (div_reg == QUARTER_LEN - 1) begin
            div_reg <= 32'h0000_0000;
            quarter_tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
            quarter_tick <= 1'b0;
        end
    end

    // quarter count: bit0 is 2 Hz, bit1 is 1 Hz, both 50 percent duty
    always_ff @(posedge clk) begin
        if (!nrst) begin
            quarter_reg <= 2'h0;
        end else if (quarter_tick) begin
            quarter_reg <= quarter_reg + 2'h1; // see RULE22
        end
    end
    assign phase_2hz = quarter_reg[0];
    assign phase_1hz = quarter_reg[1];

    // flicker free-runs far faster than either blink rate
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flick_reg <= '0;
        end else begin
            flick_reg <= flick_reg + 1'b1; // see RULE22
        end
    end
    assign phase_flicker = flick_reg[FLICKER_SHIFT-1];
endmodule // blink_timebase
`default_nettype wire

// ==== sim/led_viewer.sv ====
// operator model: measures how long one status lamp stays unchanged
`default_nettype none
module led_viewer (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // observed lamp
    input wire logic lamp,
    // cycles since the last change, and length of the last full interval
    output logic [15:0] run_len,
    output logic [15:0] last_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lamp_reg;
    // ************************************************************
    // interval measurement
    // ************************************************************
    // an eye reads a steady lamp as one long run and a blink as a fixed interval
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lamp_reg <= 1'b0;
            run_len <= 16'h0000;
            last_len <= 16'h0000;
        end else if (lamp !== lamp_reg) begin
            lamp_reg <= lamp;
            last_len <= run_len + 16'h0001;
            run_len <= 16'h0000;
        end else if (run_len != 16'hffff) begin
            run_len <= run_len + 16'h0001; // saturates so a dark lamp never wraps
        end
    end
endmodule // led_viewer
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking testbench for the status led pattern driver
`default_nettype none
module tb_top
    import led_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int QL = 8;
    localparam int OFF = 0, ON = 1, HZ1 = 2, HZ2 = 3, DC = 4;
    logic clk, nrst;
    logic cpu_startup, cpu_run, cpu_stop, cpu_error, cpu_warning, hold_point, startup_diag;
    logic sys_error_card_write, hw_config_load, blink_test, card_access;
    logic mem_reset_request, mem_reset_exec, mem_reset_done;
    logic factory_reset_exec, factory_reset_done;
    logic fw_available, fw_update_exec, fw_update_done, fw_update_fail;
    logic [NUM_DI-1:0] di_level, led_di;
    logic [NUM_DO-1:0] do_level, led_do;
    logic input_supply_good, output_supply_good, electronics_supply_good, output_fault;
    logic led_green, led_yellow, led_red, output_fault_indicator, startup_hold_active;
    logic [NUM_SUPPLY-1:0] led_supply;
    logic [2:0] lamps;
    logic [15:0] run_len [3];
    logic [15:0] last_len [3];
    int errors = 0;
    int comparisons = 0;
    assign lamps = {led_red, led_yellow, led_green};
    // ************************************************************
    // design and lamp observers
    // ************************************************************
    // a short quarter tick keeps blink intervals at 16 and 8 cycles
    status_led_pattern_driver #(.QUARTER_LEN(QL), .STARTUP_QUARTERS(12))
        u_status_led_pattern_driver (
        .clk(clk), .nrst(nrst), .cpu_startup(cpu_startup), .cpu_run(cpu_run),
        .cpu_stop(cpu_stop), .cpu_error(cpu_error), .cpu_warning(cpu_warning),
        .hold_point(hold_point), .startup_diag(startup_diag),
        .sys_error_card_write(sys_error_card_write), .hw_config_load(hw_config_load),
        .blink_test(blink_test), .card_access(card_access),
        .mem_reset_request(mem_reset_request), .mem_reset_exec(mem_reset_exec),
        .mem_reset_done(mem_reset_done), .factory_reset_exec(factory_reset_exec),
        .factory_reset_done(factory_reset_done), .fw_available(fw_available),
        .fw_update_exec(fw_update_exec), .fw_update_done(fw_update_done),
        .fw_update_fail(fw_update_fail), .di_level(di_level), .do_level(do_level),
        .input_supply_good(input_supply_good), .output_supply_good(output_supply_good),
        .electronics_supply_good(electronics_supply_good), .output_fault(output_fault),
        .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red),
        .led_di(led_di), .led_do(led_do), .led_supply(led_supply),
        .output_fault_indicator(output_fault_indicator),
        .startup_hold_active(startup_hold_active));
    for (genvar i = 0; i < 3; i++) begin : g_view
        led_viewer u_led_viewer (.clk(clk), .nrst(nrst), .lamp(lamps[i]),
            .run_len(run_len[i]), .last_len(last_len[i]));
    end
    // ************************************************************
    // clock, watchdog and shared tasks
    // ************************************************************
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a hang counts as a mismatch and still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("timeout at %0t", $time);
        final_report();
    end
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // steady lamps must show a long unchanged run; blinks a fixed half period
    task automatic lamp_chk(input int idx, input int code);
        if (code == DC) return;
        if (code < HZ1) begin
            check({31'h0, lamps[idx]}, code);
            check({31'h0, run_len[idx] > 16'h0040}, 32'h0000_0001);
        end else begin
            check({16'h0, last_len[idx]}, (code == HZ1) ? 2 * QL : QL);
        end
    endtask
    // let the pattern settle over several blink periods, then judge all three
    task automatic scene(input string name, input int g, input int y, input int r);
        repeat (80) @(negedge clk);
        lamp_chk(0, g);
        lamp_chk(1, y);
        lamp_chk(2, r);
        $display("test %s done", name);
    endtask
    task automatic clear_modes();
        {cpu_startup, cpu_run, cpu_stop, cpu_error, cpu_warning, hold_point} = 6'h00;
        {startup_diag, sys_error_card_write, hw_config_load, blink_test, card_access} = 5'h00;
        {mem_reset_request, mem_reset_exec, mem_reset_done} = 3'h0;
        {factory_reset_exec, factory_reset_done} = 2'h0;
        {fw_available, fw_update_exec, fw_update_done, fw_update_fail} = 4'h0;
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        clear_modes();
        repeat (20) @(negedge clk);
        nrst = 1'b1;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    // leaving start-up early is refused until the minimum time has run out
    task automatic test_startup();
        // diagnostics during start-up lay a red blink over the green one
        {cpu_startup, startup_diag} = 2'h3;
        repeat (8) @(negedge clk);
        cpu_startup = 1'b0;
        cpu_run = 1'b1;
        repeat (32) @(negedge clk);
        check({31'h0, startup_hold_active}, 32'h0000_0001);
        lamp_chk(0, HZ2);
        lamp_chk(2, HZ1);
        startup_diag = 1'b0;
        repeat (80) @(negedge clk);
        check({31'h0, startup_hold_active}, 32'h0000_0000);
        scene("run", ON, DC, OFF);
    endtask
    // end states after factory reset or firmware update hold until reset
    task automatic test_latched(input int kind);
        do_reset();
        cpu_stop = 1'b1;
        repeat (4) @(negedge clk);
        if (kind == 0) factory_reset_exec = 1'b1;
        else fw_update_exec = 1'b1;
        // card access during the update shows the flicker, still low this early
        card_access = (kind == 1);
        scene("update busy", DC, (kind == 1) ? OFF : HZ2, DC);
        factory_reset_exec = 1'b0;
        {fw_update_exec, card_access} = 2'h0;
        factory_reset_done = (kind == 0);
        fw_update_done = (kind == 1);
        fw_update_fail = (kind == 2);
        @(negedge clk);
        {factory_reset_done, fw_update_done, fw_update_fail} = 3'h0;
        cpu_run = 1'b1;
        scene("update end", DC, (kind == 2) ? OFF : HZ1, HZ1);
        if (kind != 2) check({31'h0, led_red ^ led_yellow}, 32'h0000_0000);
    endtask
    // channel lamps follow the synchronised field levels, lit and dark
    task automatic test_field();
        for (int k = 0; k < 2; k++) begin
            di_level = (k == 0) ? 16'ha5c3 : 16'h5a3c;
            do_level = (k == 0) ? 12'h3c5 : 12'hc3a;
            {electronics_supply_good, output_supply_good, input_supply_good} = k ? 3'h2 : 3'h5;
            output_fault = (k == 0);
            repeat (4) @(negedge clk);
            check({16'h0, led_di}, {16'h0, di_level});
            check({20'h0, led_do}, {20'h0, do_level});
            check({29'h0, led_supply}, k ? 32'h0000_0002 : 32'h0000_0005);
            check({31'h0, output_fault_indicator}, (k == 0));
        end
        $display("test field done");
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        di_level = '0;
        do_level = '0;
        {input_supply_good, output_supply_good, electronics_supply_good, output_fault} = 4'h0;
        do_reset();
        scene("power on", OFF, HZ1, OFF);
        test_startup();
        cpu_warning = 1'b1;
        scene("run warning", ON, DC, HZ1);
        // flicker has not left its low phase yet, so green reads dark
        card_access = 1'b1;
        scene("card access", OFF, DC, HZ1);
        {card_access, cpu_warning, cpu_run, cpu_stop} = 4'h1;
        scene("stop", OFF, ON, OFF);
        hold_point = 1'b1;
        scene("hold point", HZ1, DC, ON);
        clear_modes();
        cpu_error = 1'b1;
        scene("error", DC, DC, ON);
        hw_config_load = 1'b1;
        scene("config load", DC, HZ2, DC);
        {hw_config_load, blink_test} = 2'h1;
        scene("blink test", HZ1, DC, DC);
        {blink_test, startup_diag} = 2'h1;
        scene("diagnostics", HZ2, DC, HZ1);
        {startup_diag, sys_error_card_write} = 2'h1;
        scene("card write", DC, ON, ON);
        {sys_error_card_write, mem_reset_request} = 2'h1;
        scene("reset request", DC, HZ1, DC);
        {mem_reset_request, mem_reset_exec} = 2'h1;
        scene("reset exec", DC, HZ2, DC);
        {mem_reset_exec, mem_reset_done} = 2'h1;
        scene("reset done", DC, ON, DC);
        {mem_reset_done, fw_available} = 2'h1;
        scene("new firmware", DC, HZ1, HZ1);
        check({31'h0, led_red ^ led_yellow}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) test_latched(k);
        test_field();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
